// ### sadc_defs.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: Avalon-MM word addressing at byte offsets, 32-bit data
// Notes: included by the sequencer and the testbench
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH

`define SADC_OFF_CTRL     8'h00
`define SADC_OFF_CFG      8'h04
`define SADC_OFF_ACC      8'h08
`define SADC_OFF_MUX      8'h0C
`define SADC_OFF_RESH     8'h10
`define SADC_OFF_RESL     8'h14
`define SADC_OFF_STAT     8'h18

// control register fields
`define SADC_CTRL_CM_LSB  0
`define SADC_CTRL_TM      3
`define SADC_CTRL_BUSY    4
`define SADC_CTRL_DONE    5
`define SADC_CTRL_BURST   6
`define SADC_CTRL_EN      7
// config register fields
`define SADC_CFG_DIV_LSB  3
// accumulator config fields
`define SADC_ACC_RPT_LSB  0
`define SADC_ACC_SJ_LSB   3

`define SADC_CTRL_RST     8'h00
`define SADC_CFG_RST      8'hF8
`define SADC_ACC_RST      8'h00
`define SADC_MUX_RST      5'h1F

// conversion timing in conversion-clock cycles
`define SADC_TRACK_LP     4'h3
`define SADC_CONV_BITS    4'hA
`define SADC_PWRUP_CYC    8'h04
`endif

// ### sadc_pkg.sv
// Purpose: shared types of the converter sequencer
// Assumes: nothing
// Notes: constants live in sadc_defs.svh
package sadc_pkg;
  typedef enum logic [2:0] {
    SADC_SRC_SW = 3'b000,
    SADC_SRC_T0 = 3'b001,
    SADC_SRC_T2 = 3'b010,
    SADC_SRC_T3 = 3'b011,
    SADC_SRC_PIN = 3'b100,
    SADC_SRC_T1 = 3'b101
  } sadc_src_t;

  typedef enum logic [2:0] {
    SADC_IDLE = 3'b000,
    SADC_PWRUP = 3'b001,
    SADC_TRACK = 3'b010,
    SADC_CONV = 3'b011,
    SADC_DONE = 3'b100
  } sadc_state_t;

  typedef struct packed {
    logic t0_ovf;
    logic t2_lo_ovf;
    logic t2_hi_ovf;
    logic t2_split;
    logic t3_lo_ovf;
    logic t3_hi_ovf;
    logic t3_split;
  } sadc_timer_t;

  typedef struct packed {
    logic temp;
    logic vdd;
    logic ldo;
    logic gnd;
    logic pad;
  } sadc_route_t;
endpackage : sadc_pkg

// ### sadc_pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: asynchronous pin input
// Notes: level changes once stages two and three agree
`timescale 1ns/1ps
module sadc_pin_sync (
  // clock
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // pin
  input wire logic pin_in,
  output logic level_q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else if (clk_en) begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      level_q <= 1'b0;
    end else if (clk_en && (s2_q == s3_q)) begin
      level_q <= s3_q;
    end
  end
endmodule : sadc_pin_sync

// ### sadc_clk_div.sv
// Purpose: conversion-clock tick generator
// Assumes: divider field value 0 means divide by one
// Notes: emits a one-cycle tick every div+1 source ticks
`timescale 1ns/1ps
module sadc_clk_div #(
  parameter int DIV_W = 5
) (
  // clock
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // control
  input wire logic src_tick,
  input wire logic run,
  input wire logic [DIV_W-1:0] div,
  output logic tick
);
  logic [DIV_W-1:0] cnt_q;

  if (DIV_W < 1 || DIV_W > 8) begin : g_div_w_check
    $error("sadc_clk_div: DIV_W out of range");
  end

  assign tick = run && src_tick && (cnt_q == div);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (clk_en) begin
      if (!run) begin
        cnt_q <= '0;
      end else if (src_tick) begin
        cnt_q <= (cnt_q == div) ? '0 : cnt_q + 1'b1;
      end
    end
  end
endmodule : sadc_clk_div

// ### sadc_seq.sv
// Purpose: sequencer and result logic of a 10-bit SAR converter
// Assumes: the comparator gives one result bit per conversion-clock tick via sar_cmp
// Notes: Avalon-MM slave, one wait state on reads, none on writes
// How it works
// - input code 0..26 routes pads; 27 temp, 28 supply, 29 regulator, 31 ground.
// - completion loads result bytes, unused bits forced to zero.
// - single sample gives 10 bits, right justified at 000, left at 100.
// - repeat above one sums into 16 bits, result updated after last one.
// - repeat field selects 4, 8, 16, 32 or 64 samples.
// - justify field shifts the accumulated sum right by 1, 2 or 3.
// - conversion clock is system or low-power clock divided by field plus one.
// - start source picks busy write, timer 0, 2, 3 or pin rise.
// - start code 100 selects the external pin, 000 to 011 internal triggers, others none.
// - busy reads one during a conversion, clears itself on completion.
// - busy falling after the last sample sets done flag and raises interrupt when enabled.
// - timers 2 and 3 use low overflow split, high overflow otherwise.
// - normal tracking outside burst follows input continuously except while converting.
// - low-power tracking adds exactly 3 conversion clocks before converting.
// - pin trigger in low-power tracking outside burst tracks while low, converts 3 conversion clocks after the rise.
// - burst powers up, samples, accumulates, then shuts down autonomously.
// - burst launches repeat-count conversions per start; else one per start.
// - burst with enable low powers down and waits power-up at start.
`timescale 1ns/1ps
`include "sadc_defs.svh"
module sadc_seq (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // trigger sources
  input wire sadc_pkg::sadc_timer_t timers,
  input wire logic external_start_pin,
  input wire logic lpo_tick,
  // analog core
  input wire logic sar_cmp,
  output logic [9:0] sar_trial,
  output logic track_hold,
  output logic converter_on,
  output sadc_pkg::sadc_route_t route,
  output logic [4:0] pad_index,
  // events
  output logic irq
);
  logic [7:0] ctrl_q;
  logic [7:0] cfg_q;
  logic [7:0] acc_cfg_q;
  logic [4:0] input_select_reg;
  logic irq_en_q;
  logic [7:0] result_high_byte;
  logic [7:0] result_low_byte;
  sadc_pkg::sadc_state_t state_q;
  logic conversion_busy;
  logic conversion_done_flag;
  logic [15:0] acc_q;
  logic [9:0] sar_q;
  logic [3:0] bit_q;
  logic [6:0] cnt_q;
  logic [7:0] pwr_q;
  logic busy_q;
  logic rd_pend_q;
  logic pin_lvl;
  logic pin_q;
  logic pin_rise;
  logic sar_tick;
  logic sys_tick;
  logic start;
  logic sw_start;
  logic burst_enable;
  logic low_power_track_select;
  logic converter_power_enable;
  logic [6:0] repeat_n;
  logic [2:0] justify_shift_field;
  sadc_pkg::sadc_src_t start_source_field;
  logic [9:0] sample;
  logic [15:0] sum;
  logic [15:0] shaped;
  logic last_sample;
  logic wr_ctrl;

  assign burst_enable = ctrl_q[`SADC_CTRL_BURST];
  assign low_power_track_select = ctrl_q[`SADC_CTRL_TM];
  assign converter_power_enable = ctrl_q[`SADC_CTRL_EN];
  assign start_source_field = sadc_pkg::sadc_src_t'(ctrl_q[`SADC_CTRL_CM_LSB +: 3]);
  assign justify_shift_field = acc_cfg_q[`SADC_ACC_SJ_LSB +: 3];
  assign conversion_busy = busy_q;

  sadc_pin_sync u_pin (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .pin_in(external_start_pin),
    .level_q(pin_lvl)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_q <= 1'b0;
    end else if (clk_en) begin
      pin_q <= pin_lvl;
    end
  end
  assign pin_rise = pin_lvl && !pin_q;

  // conversion clock source per burst mode
  assign sys_tick = burst_enable ? lpo_tick : 1'b1;

  sadc_clk_div #(.DIV_W(5)) u_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .src_tick(sys_tick),
    .run(state_q != sadc_pkg::SADC_IDLE),
    .div(cfg_q[`SADC_CFG_DIV_LSB +: 5]),
    .tick(sar_tick)
  );

  // repeat count decode
  always_comb begin
    unique case (acc_cfg_q[`SADC_ACC_RPT_LSB +: 3])
      3'h1: repeat_n = 7'h04;
      3'h2: repeat_n = 7'h08;
      3'h3: repeat_n = 7'h10;
      3'h4: repeat_n = 7'h20;
      3'h5: repeat_n = 7'h40;
      default: repeat_n = 7'h01;
    endcase
  end

  // trigger selection
  assign wr_ctrl = avs_write && !avs_waitrequest && avs_address == `SADC_OFF_CTRL
    && avs_byteenable[0];
  assign sw_start = wr_ctrl && avs_writedata[`SADC_CTRL_BUSY];
  always_comb begin
    unique case (start_source_field)
      sadc_pkg::SADC_SRC_SW: start = sw_start;
      sadc_pkg::SADC_SRC_T0: start = timers.t0_ovf;
      sadc_pkg::SADC_SRC_T2: start = timers.t2_split ? timers.t2_lo_ovf
                                                     : timers.t2_hi_ovf;
      sadc_pkg::SADC_SRC_T3: start = timers.t3_split ? timers.t3_lo_ovf
                                                     : timers.t3_hi_ovf;
      sadc_pkg::SADC_SRC_PIN: start = pin_rise;
      default: start = 1'b0;
    endcase
  end

  // analog input routing
  always_comb begin
    route = '0;
    unique case (input_select_reg)
      5'h1B: route.temp = 1'b1;
      5'h1C: route.vdd = 1'b1;
      5'h1D: route.ldo = 1'b1;
      5'h1E: route = '0;
      5'h1F: route.gnd = 1'b1;
      default: route.pad = 1'b1;
    endcase
  end
  assign pad_index = route.pad ? input_select_reg : 5'h00;

  // keep the trial bit under test only when the comparator says the input is not below it
  assign sample = sar_cmp ? sar_q : (sar_q & ~(10'h200 >> bit_q));
  assign sum = acc_q + {6'h00, sample};
  assign last_sample = (cnt_q + 7'h01) >= repeat_n;

  // sequencer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= sadc_pkg::SADC_IDLE;
      busy_q <= 1'b0;
      cnt_q <= '0;
      bit_q <= '0;
      sar_q <= '0;
      acc_q <= '0;
      pwr_q <= '0;
    end else if (clk_en) begin
      unique case (state_q)
        sadc_pkg::SADC_IDLE: begin
          if (start) begin
            busy_q <= 1'b1;
            if (cnt_q == 7'h00) begin
              acc_q <= '0;
            end
            pwr_q <= '0;
            if (burst_enable && !converter_power_enable) begin
              state_q <= sadc_pkg::SADC_PWRUP;
            end else if (low_power_track_select || burst_enable) begin
              state_q <= sadc_pkg::SADC_TRACK;
            end else begin
              state_q <= sadc_pkg::SADC_CONV;
            end
            bit_q <= 4'h0;
            sar_q <= 10'h200;
          end
        end
        sadc_pkg::SADC_PWRUP: begin
          if (sar_tick) begin
            pwr_q <= pwr_q + 8'h01;
            if (pwr_q + 8'h01 >= `SADC_PWRUP_CYC) begin
              state_q <= sadc_pkg::SADC_TRACK;
              pwr_q <= '0;
            end
          end
        end
        sadc_pkg::SADC_TRACK: begin
          if (sar_tick) begin
            if (!low_power_track_select) begin
              state_q <= sadc_pkg::SADC_CONV;
            end else if (pwr_q[3:0] + 4'h1 >= `SADC_TRACK_LP) begin
              state_q <= sadc_pkg::SADC_CONV;
              pwr_q <= '0;
            end else begin
              pwr_q <= pwr_q + 8'h01;
            end
          end
        end
        sadc_pkg::SADC_CONV: begin
          if (sar_tick) begin
            if (bit_q == `SADC_CONV_BITS - 4'h1) begin
              acc_q <= sum;
              if (last_sample) begin
                cnt_q <= '0;
                state_q <= sadc_pkg::SADC_DONE;
              end else begin
                cnt_q <= cnt_q + 7'h01;
                if (burst_enable) begin
                  state_q <= low_power_track_select ? sadc_pkg::SADC_TRACK
                                                    : sadc_pkg::SADC_CONV;
                  sar_q <= 10'h200;
                  bit_q <= 4'h0;
                  pwr_q <= '0;
                end else begin
                  busy_q <= 1'b0;
                  state_q <= sadc_pkg::SADC_IDLE;
                end
              end
            end else begin
              sar_q <= sample | (10'h200 >> (bit_q + 4'h1));
              bit_q <= bit_q + 4'h1;
            end
          end
        end
        sadc_pkg::SADC_DONE: begin
          busy_q <= 1'b0;
          state_q <= sadc_pkg::SADC_IDLE;
        end
        default: state_q <= sadc_pkg::SADC_IDLE;
      endcase
    end
  end

  // output shaping
  always_comb begin
    if (repeat_n == 7'h01 && justify_shift_field == 3'h4) begin
      shaped = {acc_q[9:0], 6'h00};
    end else begin
      shaped = acc_q >> justify_shift_field[1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      result_high_byte <= '0;
      result_low_byte <= '0;
    end else if (clk_en && state_q == sadc_pkg::SADC_DONE) begin
      result_high_byte <= shaped[15:8];
      result_low_byte <= shaped[7:0];
    end
  end

  // done flag: busy fall after the last sample sets; set wins over a software clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      conversion_done_flag <= 1'b0;
    end else if (clk_en) begin
      if (state_q == sadc_pkg::SADC_DONE) begin
        conversion_done_flag <= 1'b1;
      end else if (wr_ctrl && !avs_writedata[`SADC_CTRL_DONE]) begin
        conversion_done_flag <= 1'b0;
      end
    end
  end
  assign irq = conversion_done_flag && irq_en_q;

  assign converter_on = (state_q != sadc_pkg::SADC_IDLE) ||
    !burst_enable && converter_power_enable || burst_enable && converter_power_enable;
  assign track_hold = (state_q == sadc_pkg::SADC_TRACK) ||
    (state_q == sadc_pkg::SADC_IDLE && !burst_enable && (!low_power_track_select ||
    (start_source_field == sadc_pkg::SADC_SRC_PIN && !pin_lvl)));
  assign sar_trial = sar_q;

  // register writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= `SADC_CTRL_RST;
      cfg_q <= `SADC_CFG_RST;
      acc_cfg_q <= `SADC_ACC_RST;
      input_select_reg <= `SADC_MUX_RST;
      irq_en_q <= 1'b0;
    end else if (clk_en && avs_write && avs_byteenable[0]) begin
      unique case (avs_address)
        `SADC_OFF_CTRL: ctrl_q <= avs_writedata[7:0] & 8'hCF;
        `SADC_OFF_CFG: cfg_q <= avs_writedata[7:0];
        `SADC_OFF_ACC: acc_cfg_q <= avs_writedata[7:0];
        `SADC_OFF_MUX: input_select_reg <= avs_writedata[4:0];
        `SADC_OFF_STAT: irq_en_q <= avs_writedata[0];
        default: ;
      endcase
    end
  end

  // reads take one wait state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_pend_q <= 1'b0;
      avs_readdata <= '0;
    end else if (clk_en) begin
      rd_pend_q <= avs_read && !rd_pend_q;
      if (avs_read && !rd_pend_q) begin
        unique case (avs_address)
          `SADC_OFF_CTRL: avs_readdata <= {24'h0000_00, ctrl_q[7:6],
            conversion_done_flag, conversion_busy, ctrl_q[3:0]};
          `SADC_OFF_CFG: avs_readdata <= {24'h0000_00, cfg_q};
          `SADC_OFF_ACC: avs_readdata <= {24'h0000_00, acc_cfg_q};
          `SADC_OFF_MUX: avs_readdata <= {27'h000_0000, input_select_reg};
          `SADC_OFF_RESH: avs_readdata <= {24'h0000_00, result_high_byte};
          `SADC_OFF_RESL: avs_readdata <= {24'h0000_00, result_low_byte};
          `SADC_OFF_STAT: avs_readdata <= {31'h0000_0000, irq_en_q};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign avs_waitrequest = avs_read && !rd_pend_q;

  chk_busy_done: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(busy_q) && $past(state_q) == sadc_pkg::SADC_DONE |-> conversion_done_flag)
    else $error("done flag not set on busy fall");
  chk_lp_track: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && state_q == sadc_pkg::SADC_TRACK && low_power_track_select && sar_tick
    |=> (state_q == sadc_pkg::SADC_CONV) == ($past(pwr_q) == 8'h02))
    else $error("low-power track length not three ticks");
  chk_busy_run: assert property (@(posedge sys_clk) disable iff (rst)
    state_q == sadc_pkg::SADC_CONV |-> busy_q)
    else $error("busy low during conversion");
  chk_ignore_start: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && start && busy_q && !sar_tick && state_q != sadc_pkg::SADC_DONE
    |=> busy_q && $stable(state_q) && $stable(cnt_q))
    else $error("start disturbed running series");
  chk_result_load: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && state_q == sadc_pkg::SADC_DONE |=> {result_high_byte, result_low_byte} ==
    $past(shaped))
    else $error("result not loaded");
  chk_route_temp: assert property (@(posedge sys_clk) disable iff (rst)
    input_select_reg == 5'h1B |-> route.temp && !route.pad)
    else $error("temperature route wrong");
  chk_left_just: assert property (@(posedge sys_clk) disable iff (rst)
    repeat_n == 7'h01 && justify_shift_field == 3'h4 |-> shaped[5:0] == 6'h00)
    else $error("left justify low bits not zero");
  chk_irq_gate: assert property (@(posedge sys_clk) disable iff (rst)
    irq |-> conversion_done_flag && irq_en_q)
    else $error("irq without enabled flag");
  cov_single: cover property (@(posedge sys_clk) state_q == sadc_pkg::SADC_DONE
    && repeat_n == 7'h01);
  cov_burst: cover property (@(posedge sys_clk) state_q == sadc_pkg::SADC_DONE && burst_enable);
  cov_pin: cover property (@(posedge sys_clk) start && start_source_field ==
    sadc_pkg::SADC_SRC_PIN);
endmodule : sadc_seq

// ### sadc_far_model.sv
// Purpose: far side of the sequencer: comparator, timers, start pin, slow clock
// Assumes: the comparator answers the trial word against a set input code
// Notes: triggers are spaced at least four clocks apart
`timescale 1ns/1ps
module sadc_far_model (
  // clock
  input wire logic sys_clk,
  // analog core
  input wire logic [9:0] sar_trial,
  output logic sar_cmp,
  // triggers
  output sadc_pkg::sadc_timer_t timers,
  output logic external_start_pin,
  output logic lpo_tick
);
  logic [9:0] target = 10'h000;

  initial begin
    timers = '0;
    external_start_pin = 1'b0;
    lpo_tick = 1'b0;
  end

  // keep the trial bit while the input is not below the trial word
  assign sar_cmp = (sar_trial <= target);

  always @(posedge sys_clk) begin
    lpo_tick <= ~lpo_tick;
  end

  task automatic fire(input logic [2:0] src);
    @(posedge sys_clk);
    case (src)
      3'h1: timers.t0_ovf <= 1'b1;
      3'h2: timers.t2_hi_ovf <= 1'b1;
      3'h3: begin
        timers.t3_split <= 1'b1;
        timers.t3_lo_ovf <= 1'b1;
      end
      default: begin
        // pin low first so the rise is seen after the synchroniser
        external_start_pin <= 1'b0;
        repeat (4) @(posedge sys_clk);
        external_start_pin <= 1'b1;
      end
    endcase
    @(posedge sys_clk);
    timers.t0_ovf <= 1'b0;
    timers.t2_hi_ovf <= 1'b0;
    timers.t3_lo_ovf <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : fire
endmodule : sadc_far_model

// ### testbench.sv
// Purpose: self-checking bench of the converter sequencer
// Assumes: far-side model answers the trial word with a chosen code
// Notes: input codes are random from a fixed seed, full scale as corner
`timescale 1ns/1ps
`include "sadc_defs.svh"
module testbench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  sadc_pkg::sadc_timer_t timers;
  sadc_pkg::sadc_route_t route;
  logic external_start_pin;
  logic lpo_tick;
  logic sar_cmp;
  logic track_hold;
  logic converter_on;
  logic irq;
  logic [9:0] sar_trial;
  logic [4:0] pad_index;
  logic [31:0] rd;
  logic [9:0] code;
  int error_cnt = 0;
  int compares = 0;
  int seed = 32'h587b;

  always #5 sys_clk = ~sys_clk;

  sadc_seq u_sadc_seq (
    .sys_clk(sys_clk), .rst(rst), .clk_en(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .timers(timers), .external_start_pin(external_start_pin), .lpo_tick(lpo_tick),
    .sar_cmp(sar_cmp), .sar_trial(sar_trial), .track_hold(track_hold),
    .converter_on(converter_on), .route(route), .pad_index(pad_index), .irq(irq)
  );

  sadc_far_model u_sadc_far_model (
    .sys_clk(sys_clk), .sar_trial(sar_trial), .sar_cmp(sar_cmp), .timers(timers),
    .external_start_pin(external_start_pin), .lpo_tick(lpo_tick)
  );

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask : check

  // one bus cycle; request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  function automatic sadc_pkg::sadc_route_t exp_route(input logic [4:0] c);
    exp_route = '0;
    exp_route.pad = (c < 5'h1B);
    exp_route.temp = (c == 5'h1B);
    exp_route.vdd = (c == 5'h1C);
    exp_route.ldo = (c == 5'h1D);
    exp_route.gnd = (c == 5'h1F);
  endfunction : exp_route

  function automatic logic [15:0] exp_res(input logic [9:0] c, input int n,
                                          input logic [2:0] sj);
    logic [15:0] s;
    s = 16'(n * c);
    if (n == 1 && sj == 3'h4) return {c, 6'h00};
    return s >> sj[1:0];
  endfunction : exp_res

  task automatic conv(input logic [2:0] sj, input logic [2:0] rpt, input logic [2:0] src,
                      input logic tm, input logic burst);
    int n;
    int k;
    logic [7:0] ctl;
    logic [15:0] e;
    n = (rpt == 3'h0) ? 1 : (4 << (rpt - 3'h1));
    ctl = {~burst, burst, 2'b00, tm, src};
    e = exp_res(code, n, sj);
    u_sadc_far_model.target = code;
    bus(1'b1, `SADC_OFF_ACC, {2'b00, sj, rpt});
    bus(1'b1, `SADC_OFF_CTRL, ctl);
    for (k = 0; k < (burst ? 1 : n); k++) begin
      if (src == 3'h0) bus(1'b1, `SADC_OFF_CTRL, ctl | 8'h10);
      else u_sadc_far_model.fire(src);
      if (burst && src == 3'h0) begin
        repeat (4) @(posedge sys_clk);
        bus(1'b1, `SADC_OFF_CTRL, ctl | 8'h10);
      end
      if (!burst && k < n - 1) begin
        rd = 32'h0000_0010;
        while (rd[4] !== 1'b0) bus(1'b0, `SADC_OFF_CTRL, 8'h00);
        check("done early", 32'h0, {31'h0, rd[5]});
      end
    end
    rd = 32'h0;
    for (k = 0; k < 2000 && rd[5] !== 1'b1; k++) bus(1'b0, `SADC_OFF_CTRL, 8'h00);
    check("done flag", 32'h1, {31'h0, rd[5]});
    @(negedge sys_clk);
    check("irq", 32'h1, {31'h0, irq});
    if (burst) check("power down", 32'h0, {31'h0, converter_on});
    @(posedge sys_clk);
    bus(1'b0, `SADC_OFF_RESH, 8'h00);
    check("result high", {24'h00_0000, e[15:8]}, rd);
    bus(1'b0, `SADC_OFF_RESL, 8'h00);
    check("result low", {24'h00_0000, e[7:0]}, rd);
    bus(1'b1, `SADC_OFF_CTRL, ctl);
    @(negedge sys_clk);
    check("irq clear", 32'h0, {31'h0, irq});
    @(posedge sys_clk);
  endtask : conv

  task automatic conclude();
    $display("counts: %0d compares, %0d mismatches", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  initial begin
    #500_000;
    error_cnt++;
    $display("unexpected run length exp finish got hang");
    conclude();
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    bus(1'b0, `SADC_OFF_CFG, 8'h00);
    check("cfg reset", 32'h0000_00F8, rd);
    bus(1'b0, `SADC_OFF_MUX, 8'h00);
    check("mux reset", 32'h0000_001F, rd);
    bus(1'b1, 8'h1C, 8'h5A);
    bus(1'b0, 8'h1C, 8'h00);
    check("unmapped", 32'h0, rd);
    check("track idle", 32'h1, {31'h0, track_hold});
    $display("test reset done");
    for (int c = 0; c < 32; c++) begin
      bus(1'b1, `SADC_OFF_MUX, 8'(c));
      check("route", {27'h0, exp_route(5'(c))}, {27'h0, route});
      check("pad index", 32'(c < 27 ? c : 0), {27'h0, pad_index});
    end
    $display("test input select done");
    bus(1'b1, `SADC_OFF_CFG, 8'h08);
    bus(1'b1, 8'h18, 8'h01);
    for (int i = 0; i < 10; i++) begin
      code = (i == 0) ? 10'h3FF : 10'($random(seed));
      conv(i[0] ? 3'h4 : 3'h0, 3'h0, 3'(i % 5), i[1], 1'b0);
    end
    $display("test single samples done");
    for (int r = 1; r < 6; r++) begin
      code = (r == 5) ? 10'h3FF : 10'($random(seed));
      conv(3'(r == 5 ? 3 : r - 1), 3'(r), 3'h0, 1'b0, r[0]);
    end
    $display("test accumulation done");
    conclude();
  end
endmodule : testbench
